// ---- hdl/flic_arbiter.sv ----
// Purpose: Picks the pending source with the highest level, ties by polling order
// Assumes: Pending bits are already gated by the enables
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "flic_regs.svh"

module flic_arbiter
(
	input wire flic_pkg::flic_srcvec_t pending,
	input wire flic_pkg::flic_srcvec_t prio_low,
	input wire flic_pkg::flic_srcvec_t prio_high,
	output logic win_valid,
	output flic_pkg::flic_src_t win_idx,
	output flic_pkg::flic_level_t win_lvl
);
	import flic_pkg::*;

	// Level of a source: high bit above low bit
	function automatic flic_level_t src_level(input logic hi, input logic lo);
		src_level = {hi, lo};
	endfunction

	// Scan in polling order; strict compare keeps the earlier source on a tie
	always_comb
	begin
		win_valid = 1'b0;
		win_idx = 3'h0;
		win_lvl = 2'h0;
		for (int i = 0; i < `FLIC_NUM_SRC; i++)
		begin
			if (pending[i] && (!win_valid || src_level(prio_high[i], prio_low[i]) > win_lvl))
			begin
				win_valid = 1'b1;
				win_idx = 3'(i);
				win_lvl = src_level(prio_high[i], prio_low[i]);
			end
		end
	end
endmodule // flic_arbiter

`default_nettype wire

// ---- hdl/flic_pkg.sv ----
// Purpose: Shared types of the interrupt control
// Assumes: Numbers live in flic_regs.svh
// Notes: Types only
package flic_pkg;
	typedef logic [2:0] flic_src_t;     // Source index in polling order
	typedef logic [1:0] flic_level_t;   // Priority level, 3 highest
	typedef logic [6:0] flic_srcvec_t;  // One bit per source
	typedef logic [15:0] flic_vec_t;    // Code address
	typedef logic [7:0] flic_byte_t;    // Register data
endpackage

// ---- hdl/flic_regs.svh ----
// Purpose: Register addresses, field positions, reset values and vectors of the interrupt control
// Assumes: Registers are reached at their byte addresses on the plain register port
// Notes: Definitions only
`ifndef FLIC_REGS_SVH
`define FLIC_REGS_SVH

// Register addresses
`define FLIC_ADDR_ENABLE 8'hA8
`define FLIC_ADDR_PRIO_LOW 8'hB8
`define FLIC_ADDR_PRIO_HIGH 8'hB7
`define FLIC_ADDR_STATUS 8'hC0
`define FLIC_ADDR_MASK 8'hC1
`define FLIC_ADDR_INSVC 8'hC2

// Number of request sources, also the polling order index
`define FLIC_NUM_SRC 7
`define FLIC_SRC_EXT0 0
`define FLIC_SRC_TIMER0 1
`define FLIC_SRC_EXT1 2
`define FLIC_SRC_TIMER1 3
`define FLIC_SRC_SERIAL0 4
`define FLIC_SRC_TIMER2 5
`define FLIC_SRC_SERIAL1 6

// Global enable position in the enable register
`define FLIC_ENABLE_GLOBAL 7

// Reset values
`define FLIC_RST_ENABLE 8'h00
`define FLIC_RST_PRIO 7'h00
`define FLIC_RST_STATUS 7'h00
`define FLIC_RST_MASK 7'h00
`define FLIC_RST_INSVC 4'h0

// Service routine entry addresses
`define FLIC_VEC_EXT0 16'h0003
`define FLIC_VEC_TIMER0 16'h000B
`define FLIC_VEC_EXT1 16'h0013
`define FLIC_VEC_TIMER1 16'h001B
`define FLIC_VEC_SERIAL0 16'h0023
`define FLIC_VEC_TIMER2 16'h002B
`define FLIC_VEC_SERIAL1 16'h0033

`endif

// ---- hdl/flic_top.sv ----
// Purpose: Seven-source, four-level interrupt control with nesting and vectoring
// Assumes: Peripheral requests come from the core clock; external pins are asynchronous
// Notes: The CPU acknowledges a shown vector with a one-cycle pulse and ends a routine likewise
//
// How it works
// - Seven sources: two pins, three timers, two serial
// - Each source has its own enable bit
// - Global enable bit seven blocks every vectored request when clear; the summary irq line still follows status and mask
// - Enable bit map: serial1 down to ext0
// - Enable register resets to all zeros
// - Level is high bit over low bit
// - Low priority bit map, bit seven reserved
// - Priority low register clears on reset
// - Second serial port vectors to its fixed address
// - Only strictly higher level preempts a routine
// - Top level routine is never preempted
// - Higher level wins among simultaneous requests
// - Polling order breaks ties within a level
// - Priority high register, same map, clears on reset
`timescale 1ns/1ps
`default_nettype none
`include "flic_regs.svh"

module flic_top
(
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire flic_pkg::flic_byte_t reg_addr,
	input wire flic_pkg::flic_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output flic_pkg::flic_byte_t reg_rdata,
	// External request pins, active low, asynchronous
	input wire logic ext_request_zero_n,
	input wire logic ext_request_one_n,
	// Peripheral request levels, core clock
	input wire logic timer0_req,
	input wire logic timer1_req,
	input wire logic timer2_req,
	input wire logic serial0_req,
	input wire logic serial1_req,
	// CPU side
	output logic cpu_irq_req,
	output flic_pkg::flic_vec_t cpu_vector,
	output flic_pkg::flic_level_t cpu_level,
	input wire logic cpu_ack,
	input wire logic cpu_reti,
	// Summary interrupt line
	output logic irq
);
	import flic_pkg::*;

	// Enable register, bit 7 global
	flic_byte_t enable_r, enable_nxt;
	// Priority bits, reserved bit 7 is not stored
	flic_srcvec_t prio_low_r, prio_low_nxt;
	flic_srcvec_t prio_high_r, prio_high_nxt;
	// Sticky pending status and its summary mask
	flic_srcvec_t status_r, status_nxt;
	flic_srcvec_t mask_r, mask_nxt;
	// One bit per level currently in service
	logic [3:0] insvc_r, insvc_nxt;
	// Pin synchronisers, idle high
	logic ext0_s1_r, ext0_s2_r;
	logic ext1_s1_r, ext1_s2_r;
	// Previous request levels for edge detection
	flic_srcvec_t req_prev_r, req_prev_nxt;
	// Registered grant shown to the CPU
	logic req_r, req_nxt;
	flic_src_t gidx_r, gidx_nxt;
	flic_level_t glvl_r, glvl_nxt;
	flic_vec_t vec_r, vec_nxt;
	// Read data, valid only the cycle after a read strobe
	flic_byte_t rdata_r, rdata_nxt;

	// Combinational helpers
	flic_srcvec_t req_now;      // Request levels in polling order
	flic_srcvec_t req_rise;     // New request events
	flic_srcvec_t enabled_pend; // Pending and allowed
	logic arb_valid;
	flic_src_t arb_idx;
	flic_level_t arb_lvl;
	logic cur_any;
	flic_level_t cur_lvl;
	logic may_preempt;

	// Highest level in service; used for preemption and for the return pop
	function automatic logic [2:0] top_level(input logic [3:0] act);
		top_level = 3'h0;
		for (int l = 0; l < 4; l++)
		begin
			if (act[l])
			begin
				top_level = {1'b1, 2'(l)};
			end
		end
	endfunction

	// Entry address per source
	function automatic flic_vec_t vector_of(input flic_src_t idx);
		case (idx)
			3'h0: vector_of = `FLIC_VEC_EXT0;
			3'h1: vector_of = `FLIC_VEC_TIMER0;
			3'h2: vector_of = `FLIC_VEC_EXT1;
			3'h3: vector_of = `FLIC_VEC_TIMER1;
			3'h4: vector_of = `FLIC_VEC_SERIAL0;
			3'h5: vector_of = `FLIC_VEC_TIMER2;
			default: vector_of = `FLIC_VEC_SERIAL1;
		endcase
	endfunction

	// Two flops on each pin before anything looks at it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext0_s1_r <= 1'b1;
			ext0_s2_r <= 1'b1;
			ext1_s1_r <= 1'b1;
			ext1_s2_r <= 1'b1;
		end
		else
		begin
			ext0_s1_r <= ext_request_zero_n;
			ext0_s2_r <= ext0_s1_r;
			ext1_s1_r <= ext_request_one_n;
			ext1_s2_r <= ext1_s1_r;
		end
	end

	// Gather the seven sources in polling order
	always_comb
	begin
		req_now = 7'h00;
		req_now[`FLIC_SRC_EXT0] = ~ext0_s2_r;
		req_now[`FLIC_SRC_TIMER0] = timer0_req;
		req_now[`FLIC_SRC_EXT1] = ~ext1_s2_r;
		req_now[`FLIC_SRC_TIMER1] = timer1_req;
		req_now[`FLIC_SRC_SERIAL0] = serial0_req;
		req_now[`FLIC_SRC_TIMER2] = timer2_req;
		req_now[`FLIC_SRC_SERIAL1] = serial1_req;
		// A held level counts once; a source must drop and rise to ask again
		req_rise = req_now & ~req_prev_r;
	end

	// Gate pending requests by the source enables and the global enable
	always_comb
	begin
		enabled_pend = status_r & enable_r[6:0];
		if (!enable_r[`FLIC_ENABLE_GLOBAL])
		begin
			enabled_pend = 7'h00;
		end
	end

	// Level and tie resolution
	flic_arbiter u_arbiter
	(
		.pending(enabled_pend),
		.prio_low(prio_low_r),
		.prio_high(prio_high_r),
		.win_valid(arb_valid),
		.win_idx(arb_idx),
		.win_lvl(arb_lvl)
	);

	// Nesting: only a strictly higher level breaks in; level 3 is never exceeded
	always_comb
	begin
		{cur_any, cur_lvl} = top_level(insvc_r);
		may_preempt = arb_valid && (!cur_any || (arb_lvl > cur_lvl));
	end

	// Next state of registers, status, nesting and read data
	always_comb
	begin
		enable_nxt = enable_r;
		prio_low_nxt = prio_low_r;
		prio_high_nxt = prio_high_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		insvc_nxt = insvc_r;
		req_prev_nxt = req_now;
		rdata_nxt = 8'h00;
		// Register writes
		if (reg_wr)
		begin
			if (reg_addr == `FLIC_ADDR_ENABLE)
			begin
				enable_nxt = reg_wdata;
			end
			else if (reg_addr == `FLIC_ADDR_PRIO_LOW)
			begin
				// Reserved top bit dropped; software keeps it zero anyway
				prio_low_nxt = reg_wdata[6:0];
			end
			else if (reg_addr == `FLIC_ADDR_PRIO_HIGH)
			begin
				prio_high_nxt = reg_wdata[6:0];
			end
			else if (reg_addr == `FLIC_ADDR_STATUS)
			begin
				// Write one to clear
				status_nxt = status_nxt & ~reg_wdata[6:0];
			end
			else if (reg_addr == `FLIC_ADDR_MASK)
			begin
				mask_nxt = reg_wdata[6:0];
			end
		end
		// Return from a routine ends the innermost level
		if (cpu_reti && cur_any)
		begin
			insvc_nxt[cur_lvl] = 1'b0;
		end
		// Acknowledge: level enters service, its pending bit clears
		if (cpu_ack && req_r)
		begin
			insvc_nxt = insvc_nxt | (4'h1 << glvl_r);
			status_nxt = status_nxt & ~(7'h01 << gidx_r);
		end
		// New events last so that a set beats any clear in the same cycle
		status_nxt = status_nxt | req_rise;
		// Reads; reserved and unmapped bits read zero
		if (reg_rd)
		begin
			if (reg_addr == `FLIC_ADDR_ENABLE)
			begin
				rdata_nxt = enable_r;
			end
			else if (reg_addr == `FLIC_ADDR_PRIO_LOW)
			begin
				rdata_nxt = {1'b0, prio_low_r};
			end
			else if (reg_addr == `FLIC_ADDR_PRIO_HIGH)
			begin
				rdata_nxt = {1'b0, prio_high_r};
			end
			else if (reg_addr == `FLIC_ADDR_STATUS)
			begin
				rdata_nxt = {1'b0, status_r};
			end
			else if (reg_addr == `FLIC_ADDR_MASK)
			begin
				rdata_nxt = {1'b0, mask_r};
			end
			else if (reg_addr == `FLIC_ADDR_INSVC)
			begin
				rdata_nxt = {4'h0, insvc_r};
			end
		end
	end

	// Grant shown to the CPU; dropped for a cycle after an acknowledge so
	// that the stale winner is never offered twice
	always_comb
	begin
		req_nxt = may_preempt && !cpu_ack;
		gidx_nxt = gidx_r;
		glvl_nxt = glvl_r;
		vec_nxt = vec_r;
		if (may_preempt)
		begin
			gidx_nxt = arb_idx;
			glvl_nxt = arb_lvl;
			vec_nxt = vector_of(arb_idx);
		end
	end

	// Register everything
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_r <= `FLIC_RST_ENABLE;
			prio_low_r <= `FLIC_RST_PRIO;
			prio_high_r <= `FLIC_RST_PRIO;
			status_r <= `FLIC_RST_STATUS;
			mask_r <= `FLIC_RST_MASK;
			insvc_r <= `FLIC_RST_INSVC;
			req_prev_r <= 7'h00;
			req_r <= 1'b0;
			gidx_r <= 3'h0;
			glvl_r <= 2'h0;
			vec_r <= 16'h0000;
			rdata_r <= 8'h00;
		end
		else
		begin
			enable_r <= enable_nxt;
			prio_low_r <= prio_low_nxt;
			prio_high_r <= prio_high_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			insvc_r <= insvc_nxt;
			req_prev_r <= req_prev_nxt;
			req_r <= req_nxt;
			gidx_r <= gidx_nxt;
			glvl_r <= glvl_nxt;
			vec_r <= vec_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Outputs
	assign reg_rdata = rdata_r;
	assign cpu_irq_req = req_r;
	assign cpu_vector = vec_r;
	assign cpu_level = glvl_r;
	// Summary line ignores the enables; software may poll without vectoring
	assign irq = |(status_r & mask_r);
endmodule // flic_top

`default_nettype wire

// ---- tb/flic_cpu_model.sv ----
// Purpose: Core stand-in that takes shown vectors and ends routines
// Assumes: Routines last twelve cycles, ack delay set by the bench
// Notes: Nested routines end innermost first
`timescale 1ns/1ps
`default_nettype none
module flic_cpu_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_irq_req,
	input wire logic [3:0] ack_lat,
	output logic cpu_ack,
	output logic cpu_reti
);
	logic [3:0] wait_r; // Cycles the vector has been shown
	logic [3:0] depth_r; // Open routines
	logic [3:0] run_r; // Cycles left in the innermost routine
	// Take and return, one pulse each
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_ack <= 1'b0;
			cpu_reti <= 1'b0;
			wait_r <= 4'h0;
			depth_r <= 4'h0;
			run_r <= 4'h0;
		end
		else
		begin
			cpu_ack <= 1'b0;
			cpu_reti <= 1'b0;
			wait_r <= (cpu_irq_req && !cpu_ack) ? wait_r + 4'h1 : 4'h0;
			if (cpu_irq_req && !cpu_ack && wait_r >= ack_lat)
			begin
				// Not twice in a row: the request drops after a take
				cpu_ack <= 1'b1;
				depth_r <= depth_r + 4'h1;
				run_r <= 4'hC;
			end
			else if (depth_r != 4'h0 && run_r == 4'h0)
			begin
				cpu_reti <= 1'b1;
				depth_r <= depth_r - 4'h1;
				run_r <= 4'hC;
			end
			else if (run_r != 4'h0)
				run_r <= run_r - 4'h1;
		end
	end
endmodule // flic_cpu_model
`default_nettype wire

// ---- tb/flic_sva.sv ----
// Purpose: Port checks of the interrupt control
// Assumes: Enable register mirrored from bus writes
// Notes: Bound into flic_top
`timescale 1ns/1ps
`default_nettype none
`include "flic_regs.svh"
module flic_sva
(
	input wire logic clk,
	input wire logic rst_n,
	input wire flic_pkg::flic_byte_t reg_addr,
	input wire flic_pkg::flic_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire flic_pkg::flic_byte_t reg_rdata,
	input wire logic cpu_irq_req,
	input wire flic_pkg::flic_vec_t cpu_vector,
	input wire flic_pkg::flic_level_t cpu_level,
	input wire logic cpu_ack
);
	import flic_pkg::*;
	flic_byte_t enable_r; // Mirror of the enable register
	flic_byte_t enable_q; // One cycle late, since the request output is registered
	// Mirror update
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_r <= 8'h00;
			enable_q <= 8'h00;
		end
		else
		begin
			if (reg_wr && reg_addr == `FLIC_ADDR_ENABLE)
				enable_r <= reg_wdata;
			enable_q <= enable_r;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A vector taken by the core
	sequence s_take;
		cpu_ack && cpu_irq_req;
	endsequence
	// A top level vector taken
	sequence s_top_take;
		s_take ##0 cpu_level == 2'h3;
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside a read slot");
	a_enable_read: assert property (
		reg_rd && reg_addr == `FLIC_ADDR_ENABLE |=> reg_rdata == enable_r)
		else $error("enable register read wrong");
	a_rsv_bit: assert property (reg_rd && reg_addr[7:4] == 4'hB |=> !reg_rdata[7])
		else $error("reserved priority bit read set");
	a_insvc_bits: assert property (
		reg_rd && reg_addr == `FLIC_ADDR_INSVC |=> reg_rdata[7:4] == 4'h0)
		else $error("in-service register high bits set");
	a_vec_map: assert property (cpu_irq_req |->
		cpu_vector[2:0] == 3'h3 && cpu_vector[15:6] == 10'h000 && cpu_vector[5:3] != 3'h7)
		else $error("vector outside the table");
	a_enable_gate: assert property (
		cpu_irq_req |-> enable_q[7] && enable_q[cpu_vector[5:3]])
		else $error("vector shown for a disabled source");
	a_ack_drop: assert property (s_take |=> !cpu_irq_req)
		else $error("request stays after ack");
	a_top_hold: assert property (s_top_take |=> !cpu_irq_req [*8])
		else $error("top level routine preempted");
endmodule // flic_sva
bind flic_top flic_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level),
	.cpu_ack(cpu_ack));
`default_nettype wire

// ---- tb/test_four_level_interrupt_control.sv ----
// Purpose: Self-checking bench of the interrupt control
// Assumes: Core stand-in returns twelve cycles after each take
// Notes: Expected reads and takes wait in queues for the monitor
`timescale 1ns/1ps
`default_nettype none
`include "flic_regs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_four_level_interrupt_control;
	import flic_pkg::*;
	logic clk, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	flic_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, eb, en, pl, ph;
	logic [6:0] src = 7'h00; // Request per source, active high
	logic [3:0] lat = 4'h0; // Core ack delay
	logic cpu_irq_req, cpu_ack, cpu_reti, irq;
	flic_vec_t cpu_vector;
	flic_level_t cpu_level;
	logic [17:0] ev; // Level over vector
	flic_byte_t rq[$];
	logic [17:0] vq[$];
	int n_mismatch = 0, compares = 0, seed = 32'hC4EF5574;
	flic_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_request_zero_n(!src[0]),
		.ext_request_one_n(!src[2]), .timer0_req(src[1]), .timer1_req(src[3]),
		.timer2_req(src[5]), .serial0_req(src[4]), .serial1_req(src[6]),
		.cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level),
		.cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .irq(irq));
	flic_cpu_model cpu (.clk(clk), .rst_n(rst_n), .cpu_irq_req(cpu_irq_req), .ack_lat(lat),
		.cpu_ack(cpu_ack), .cpu_reti(cpu_reti));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic wr(input flic_byte_t a, input flic_byte_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input flic_byte_t a, input flic_byte_t e);
		rq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	// Pins lead by two cycles to make up for their synchroniser
	task automatic fire(input logic [6:0] m);
		if ((m & 7'h05) != 7'h00)
		begin
			src <= m & 7'h05;
			repeat (2) @(posedge clk);
		end
		src <= m;
		repeat (2) @(posedge clk);
		src <= 7'h00;
		@(posedge clk);
	endtask
	task automatic wait_take();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!(cpu_ack && cpu_irq_req) && n < 100);
	endtask
	task automatic drain(input string s);
		for (int i = 0; i < 800 && vq.size() != 0; i++)
			@(posedge clk);
		repeat (40) @(posedge clk);
		`CHK("left", 32'h0, vq.size())
		$display("test %s done", s);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Monitor: each read slot and each take pops the oldest note
	always @(posedge clk)
	begin
		rd_d <= reg_rd;
		if (rd_d)
		begin
			eb = rq.pop_front();
			`CHK("reg_rdata", eb, reg_rdata)
		end
		if (cpu_ack && cpu_irq_req)
		begin
			ev = (vq.size() != 0) ? vq.pop_front() : 18'h3FFFF;
			`CHK("take", ev, {cpu_level, cpu_vector})
		end
	end
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`FLIC_ADDR_ENABLE, 8'h00);
		rd(`FLIC_ADDR_PRIO_LOW, 8'h00);
		rd(`FLIC_ADDR_PRIO_HIGH, 8'h00);
		wr(`FLIC_ADDR_ENABLE, 8'h25);
		rd(`FLIC_ADDR_ENABLE, 8'h25);
		wr(`FLIC_ADDR_PRIO_LOW, 8'h7F);
		rd(`FLIC_ADDR_PRIO_LOW, 8'h7F);
		wr(`FLIC_ADDR_INSVC, 8'h0F);
		rd(`FLIC_ADDR_INSVC, 8'h00);
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		repeat (2) @(posedge clk);
		$display("test registers done");
		// Disabled source stays pending and raises the summary line
		wr(`FLIC_ADDR_ENABLE, 8'h00);
		wr(`FLIC_ADDR_MASK, 8'h02);
		fire(7'h02);
		`CHK("irq", 1'b1, irq)
		rd(`FLIC_ADDR_STATUS, 8'h02);
		wr(`FLIC_ADDR_STATUS, 8'h02);
		`CHK("irq", 1'b0, irq)
		wr(`FLIC_ADDR_MASK, 8'h00);
		fire(7'h02);
		`CHK("irq", 1'b0, irq)
		$display("test summary done");
		// Global enable clear holds the pending timer back
		wr(`FLIC_ADDR_ENABLE, 8'h7F);
		repeat (20) @(posedge clk);
		vq.push_back({2'h1, 16'h000B});
		wr(`FLIC_ADDR_ENABLE, 8'hFF);
		drain("enables");
		// Nesting: only a strictly higher level preempts
		wr(`FLIC_ADDR_PRIO_LOW, 8'h78);
		wr(`FLIC_ADDR_PRIO_HIGH, 8'h60);
		vq = '{18'h0000B, 18'h1001B, 18'h30033, 18'h3002B, 18'h10023};
		fire(7'h02);
		wait_take();
		fire(7'h08);
		wait_take();
		fire(7'h10);
		fire(7'h40);
		wait_take();
		fire(7'h20);
		drain("nesting");
		// All seven together, random levels and enables
		repeat (4)
		begin
			en = {1'b1, 7'($random(seed))};
			pl = {1'b0, 7'($random(seed))};
			ph = {1'b0, 7'($random(seed))};
			lat <= 4'h3 + 4'($random(seed) & 3);
			wr(`FLIC_ADDR_STATUS, 8'h7F);
			wr(`FLIC_ADDR_ENABLE, en);
			wr(`FLIC_ADDR_PRIO_LOW, pl);
			wr(`FLIC_ADDR_PRIO_HIGH, ph);
			rd(`FLIC_ADDR_PRIO_HIGH, ph);
			for (int l = 3; l >= 0; l--)
				for (int i = 0; i < 7; i++)
					if (en[i] && {ph[i], pl[i]} == l[1:0])
						vq.push_back({l[1:0], 16'h0003 + 16'(8 * i)});
			fire(7'h7F);
			drain("polling");
		end
		end_of_test();
	end
endmodule // test_four_level_interrupt_control
`default_nettype wire
